// file: logic/program_memory_table_read.sv
// program fetch, table read and serial programming access to the store
`timescale 1ns/1ps
//
// Contract
// - the store holds 8K words of 16 bits for code, tables and entries.
// - after reset the program counter is 0000H and fetching starts there.
// - a table read may address any word, independent of the program counter.
// - the table address is the high pointer joined above the low pointer.
// - a table read writes the word's low byte to the named data location.
// - a table read writes the word's high byte into the high latch.
// - the plain form targets sector 0, the extended form any sector.
// - a table read takes two cycles and stalls the pipeline meanwhile.
// - software can read and write the high latch to save and restore it.
// - programming uses one two-way data line clocked by the programmer.
module program_memory_table_read (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // instruction fetch
    input wire logic fetchAdvance,
    input wire logic pcLoad,
    input wire pmt_pkg::addr_t pcLoadAddr,
    output pmt_pkg::addr_t pc_r,
    output logic instrValid_r,
    output pmt_pkg::addr_t instrAddr_r,
    output pmt_pkg::word_t instrWord_r,
    // table read command
    input wire logic tableReadStart,
    input wire logic tableReadExtended,
    input wire pmt_pkg::byte_t tablePtrLow,
    input wire pmt_pkg::byte_t tablePtrHigh,
    input wire pmt_pkg::sector_t destSector,
    input wire pmt_pkg::byte_t destOffset,
    output logic tableBusy_r,
    output logic dmWrEn_r,
    output pmt_pkg::dm_addr_t dmWrAddr_r,
    output pmt_pkg::byte_t dmWrData_r,
    // high latch software access
    input wire logic latchWrEn,
    input wire pmt_pkg::byte_t latchWrData,
    output pmt_pkg::byte_t tableDataHighLatch_r,
    // programming port pins
    input wire logic programPortClockLine,
    input wire logic programPortDataLineIn,
    output logic programPortDataLineOut_r,
    output logic programPortDataLineOe_r
);
    import pmt_pkg::*;

    // ========================================
    // reset release
    logic [1:0] rstPipe_r;
    logic rstN;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstPipe_r <= 2'h0;
        end else begin
            rstPipe_r <= {rstPipe_r[0], 1'h1};
        end
    end
    assign rstN = rstPipe_r[1];

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstN);

    // ========================================
    // store
    prog_store_if mif ();

    prog_store #(.DEPTH(PROG_DEPTH)) uStore (
        .clk(core_clk),
        .port(mif.store)
    );

    // ========================================
    // table read sequencer
    tbl_state_t state_r;
    addr_t tblAddr_r;
    dm_addr_t dest_r;
    logic takeTable;
    addr_t ptrAddr;
    byte_t rdLow;
    byte_t rdHigh;

    assign takeTable = (state_r == TBL_IDLE) && tableReadStart;
    assign ptrAddr = {tablePtrHigh[PTR_HI_USED-1:0], tablePtrLow};
    assign rdLow = mif.rdData[BYTE_W-1:0];
    assign rdHigh = mif.rdData[WORD_W-1:BYTE_W];

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            state_r <= TBL_IDLE;
        end else begin
            case (state_r)
                TBL_IDLE: begin
                    if (tableReadStart) begin
                        state_r <= TBL_FETCH;
                    end
                end
                TBL_FETCH: state_r <= TBL_WRITE;
                TBL_WRITE: state_r <= TBL_IDLE;
                default: state_r <= TBL_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            tblAddr_r <= '0;
            dest_r <= '0;
        end else if (takeTable) begin
            tblAddr_r <= ptrAddr;
            // plain form always lands in sector 0
            dest_r <= {tableReadExtended ? destSector : SECTOR0,
                destOffset};
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            tableBusy_r <= 1'h0;
        end else begin
            tableBusy_r <= takeTable || (state_r == TBL_FETCH);
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            dmWrEn_r <= 1'h0;
            dmWrAddr_r <= '0;
            dmWrData_r <= '0;
        end else begin
            dmWrEn_r <= (state_r == TBL_WRITE);
            if (state_r == TBL_WRITE) begin
                dmWrAddr_r <= dest_r;
                dmWrData_r <= rdLow;
            end
        end
    end

    // hardware update wins over a software write in the same cycle
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            tableDataHighLatch_r <= '0;
        end else if (state_r == TBL_WRITE) begin
            tableDataHighLatch_r <= rdHigh;
        end else if (latchWrEn) begin
            tableDataHighLatch_r <= latchWrData;
        end
    end

    // ========================================
    // instruction fetch
    logic fetchGo;
    logic loadGo;
    logic fetchIssued_r;
    addr_t fetchAddr_r;

    // a table start in the same cycle takes precedence over fetch
    assign loadGo = (state_r == TBL_IDLE) && !tableReadStart && pcLoad;
    assign fetchGo = (state_r == TBL_IDLE) && !tableReadStart
        && !pcLoad && fetchAdvance;
    assign mif.rdAddr = (state_r == TBL_FETCH) ? tblAddr_r : pc_r;

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            pc_r <= RESET_VECTOR;
        end else if (loadGo) begin
            pc_r <= pcLoadAddr;
        end else if (fetchGo) begin
            pc_r <= pc_r + 1'h1;
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            fetchIssued_r <= 1'h0;
            fetchAddr_r <= '0;
        end else begin
            fetchIssued_r <= fetchGo;
            if (fetchGo) begin
                fetchAddr_r <= pc_r;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            instrValid_r <= 1'h0;
            instrAddr_r <= '0;
            instrWord_r <= '0;
        end else begin
            instrValid_r <= fetchIssued_r;
            if (fetchIssued_r) begin
                instrAddr_r <= fetchAddr_r;
                instrWord_r <= mif.rdData;
            end
        end
    end

    // ========================================
    // programming port
    logic clkMeta_r, clkSync_r, clkPrev_r;
    logic datMeta_r, datSync_r;
    logic icpRise, icpFall;
    logic [ICP_CNT_W-1:0] icpCnt_r;
    logic [ICP_FRAME_BITS-2:0] icpShift_r;
    logic icpRdReq_r, icpLoad_r, icpReading_r;
    addr_t icpAddr_r;
    word_t outShift_r;
    logic icpWrEn_r;
    addr_t icpWrAddr_r;
    word_t icpWrData_r;

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            clkMeta_r <= 1'h0;
            clkSync_r <= 1'h0;
            clkPrev_r <= 1'h0;
            datMeta_r <= 1'h0;
            datSync_r <= 1'h0;
        end else begin
            clkMeta_r <= programPortClockLine;
            clkSync_r <= clkMeta_r;
            clkPrev_r <= clkSync_r;
            datMeta_r <= programPortDataLineIn;
            datSync_r <= datMeta_r;
        end
    end

    assign icpRise = clkSync_r && !clkPrev_r;
    assign icpFall = !clkSync_r && clkPrev_r;

    // frames are counted from reset; a lost edge shifts all later frames
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            icpCnt_r <= '0;
            icpShift_r <= '0;
        end else if (icpRise) begin
            icpShift_r <= {icpShift_r[ICP_FRAME_BITS-3:0], datSync_r};
            icpCnt_r <= (icpCnt_r == ICP_FRAME_LAST) ? '0
                : icpCnt_r + 1'h1;
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            icpWrEn_r <= 1'h0;
            icpWrAddr_r <= '0;
            icpWrData_r <= '0;
        end else begin
            icpWrEn_r <= icpRise && (icpCnt_r == ICP_FRAME_LAST)
                && (icpShift_r[ICP_FRAME_BITS-2] == ICP_CMD_WRITE);
            if (icpRise && (icpCnt_r == ICP_FRAME_LAST)) begin
                icpWrAddr_r <= icpShift_r[ICP_FRAME_BITS-3:WORD_W-1];
                icpWrData_r <= {icpShift_r[WORD_W-2:0], datSync_r};
            end
        end
    end

    assign mif.wrEn = icpWrEn_r;
    assign mif.wrAddr = icpWrAddr_r;
    assign mif.wrData = icpWrData_r;
    assign mif.auxAddr = icpAddr_r;

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            icpRdReq_r <= 1'h0;
            icpLoad_r <= 1'h0;
            icpAddr_r <= '0;
        end else begin
            icpRdReq_r <= icpRise && (icpCnt_r == ICP_HDR_LAST)
                && (icpShift_r[ADDR_W-1] != ICP_CMD_WRITE);
            icpLoad_r <= icpRdReq_r;
            if (icpRise && (icpCnt_r == ICP_HDR_LAST)) begin
                icpAddr_r <= {icpShift_r[ADDR_W-2:0], datSync_r};
            end
        end
    end

    // read data leaves on falling edges, the programmer samples on rising
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            icpReading_r <= 1'h0;
            outShift_r <= '0;
            programPortDataLineOut_r <= 1'h0;
            programPortDataLineOe_r <= 1'h0;
        end else begin
            if (icpRdReq_r) begin
                icpReading_r <= 1'h1;
            end else if (icpRise && (icpCnt_r == ICP_FRAME_LAST)) begin
                icpReading_r <= 1'h0;
                programPortDataLineOe_r <= 1'h0;
            end
            if (icpLoad_r) begin
                outShift_r <= mif.auxData;
            end else if (icpFall && icpReading_r) begin
                programPortDataLineOut_r <= outShift_r[WORD_W-1];
                programPortDataLineOe_r <= 1'h1;
                outShift_r <= {outShift_r[WORD_W-2:0], 1'h0};
            end
        end
    end

    // ========================================
    // checks
    addr_t ptrPast;
    logic firstFetch_r;

    assign ptrPast = ptrAddr;

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            firstFetch_r <= 1'h1;
        end else if (instrValid_r || loadGo) begin
            firstFetch_r <= 1'h0;
        end
    end

    property p_first_fetch;
        instrValid_r && firstFetch_r |-> instrAddr_r == RESET_VECTOR;
    endproperty
    a_first_fetch: assert property (p_first_fetch)
        else $error("first fetched word not from reset vector");

    property p_table_stall;
        takeTable |=> tableBusy_r [*2] ##1 !tableBusy_r;
    endproperty
    a_table_stall: assert property (p_table_stall)
        else $error("table read stall is not two cycles");

    property p_table_done;
        takeTable |-> ##3 dmWrEn_r;
    endproperty
    a_table_done: assert property (p_table_done)
        else $error("table result not written three cycles after start");

    property p_ptr;
        takeTable |=> mif.rdAddr == $past(ptrPast);
    endproperty
    a_ptr: assert property (p_ptr)
        else $error("table address differs from pointer registers");

    property p_low_byte;
        state_r == TBL_WRITE |=> dmWrEn_r && dmWrData_r == $past(rdLow);
    endproperty
    a_low_byte: assert property (p_low_byte)
        else $error("data memory did not get the low table byte");

    property p_high_byte;
        dmWrEn_r |-> tableDataHighLatch_r == $past(rdHigh);
    endproperty
    a_high_byte: assert property (p_high_byte)
        else $error("high latch did not get the high table byte");

    property p_sector;
        takeTable && !tableReadExtended
            |-> ##3 dmWrAddr_r[SECTOR_W+BYTE_W-1:BYTE_W] == SECTOR0;
    endproperty
    a_sector: assert property (p_sector)
        else $error("plain table read left sector zero");

    property p_latch_sw;
        latchWrEn && state_r != TBL_WRITE
            |=> tableDataHighLatch_r == $past(latchWrData);
    endproperty
    a_latch_sw: assert property (p_latch_sw)
        else $error("software write to high latch lost");

    property p_pc_hold;
        tableBusy_r |=> $stable(pc_r);
    endproperty
    a_pc_hold: assert property (p_pc_hold)
        else $error("program counter moved during table stall");

    property p_icp_write;
        icpRise && icpCnt_r == ICP_FRAME_LAST
            && icpShift_r[ICP_FRAME_BITS-2] == ICP_CMD_WRITE |=> mif.wrEn;
    endproperty
    a_icp_write: assert property (p_icp_write)
        else $error("programming write frame did not write the store");

    property p_icp_oe;
        programPortDataLineOe_r |-> icpReading_r;
    endproperty
    a_icp_oe: assert property (p_icp_oe)
        else $error("data line driven outside a read frame");

    c_ext_read: cover property (takeTable && tableReadExtended ##3 dmWrEn_r);
    c_first: cover property (instrValid_r && firstFetch_r);
    c_icp_wr: cover property (mif.wrEn);
    c_icp_rd: cover property ($rose(programPortDataLineOe_r));
endmodule

// file: shared/pmt_pkg.sv
// constants and types for the program store and table read block
package pmt_pkg;

    // ========================================
    // store geometry
    localparam int ADDR_W = 13;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int PROG_DEPTH = 8192;
    localparam int PTR_HI_USED = 5;

    // ========================================
    // data memory destination
    localparam int SECTOR_W = 3;
    localparam logic [SECTOR_W-1:0] SECTOR0 = 3'h0;

    // ========================================
    // reset values
    localparam logic [ADDR_W-1:0] RESET_VECTOR = 13'h0000;

    // ========================================
    // programming port frame: cmd bit, address, data
    localparam int ICP_CNT_W = 5;
    localparam logic [ICP_CNT_W-1:0] ICP_HDR_LAST = 5'h0D;
    localparam logic [ICP_CNT_W-1:0] ICP_FRAME_LAST = 5'h1D;
    localparam int ICP_FRAME_BITS = 30;
    localparam logic ICP_CMD_WRITE = 1'h1;

    // ========================================
    // types
    typedef logic [ADDR_W-1:0] addr_t;
    typedef logic [WORD_W-1:0] word_t;
    typedef logic [BYTE_W-1:0] byte_t;
    typedef logic [SECTOR_W-1:0] sector_t;
    typedef logic [SECTOR_W+BYTE_W-1:0] dm_addr_t;
    typedef enum logic [1:0] {TBL_IDLE, TBL_FETCH, TBL_WRITE} tbl_state_t;

endpackage

// file: shared/prog_store_if.sv
// connection between the access logic and the program store array
`timescale 1ns/1ps
interface prog_store_if;
    import pmt_pkg::*;

    // ========================================
    // fetch and table read port
    addr_t rdAddr;
    word_t rdData;
    // programming port read
    addr_t auxAddr;
    word_t auxData;
    // programming port write
    logic wrEn;
    addr_t wrAddr;
    word_t wrData;

    modport store (
        input rdAddr, auxAddr, wrEn, wrAddr, wrData,
        output rdData, auxData
    );
    modport client (
        output rdAddr, auxAddr, wrEn, wrAddr, wrData,
        input rdData, auxData
    );
endinterface

// file: logic/prog_store.sv
// program store array with two registered read ports and one write port
`timescale 1ns/1ps
module prog_store #(
    parameter int DEPTH = pmt_pkg::PROG_DEPTH
) (
    // clock
    input wire logic clk,
    // array access
    prog_store_if.store port
);
    import pmt_pkg::*;

    // ========================================
    // array, no reset so it maps onto memory cells
    word_t mem [DEPTH];

    always_ff @(posedge clk) begin
        if (port.wrEn) begin
            mem[port.wrAddr] <= port.wrData;
        end
    end

    always_ff @(posedge clk) begin
        port.rdData <= mem[port.rdAddr];
    end

    always_ff @(posedge clk) begin
        port.auxData <= mem[port.auxAddr];
    end
endmodule

// file: testbench/icp_programmer.sv
// model of the external programmer on the serial programming pins
`timescale 1ns/1ps
module icp_programmer (
    // clock
    input wire logic core_clk,
    // pins
    input wire logic pinLevel,
    output logic clkLine,
    output logic dataDrive,
    output logic dataOe
);
    import pmt_pkg::*;

    initial begin
        clkLine = 1'h0;
        dataDrive = 1'h0;
        dataOe = 1'h0;
    end

    // ========================================
    // one frame: cmd, address, data, msb first
    // phases of five core cycles keep above the four-cycle minimum
    task automatic sendFrame(input logic cmd, input addr_t a, input word_t d,
                             output word_t rd);
        logic [ICP_FRAME_BITS-1:0] bits;
        int i;
        bits = {cmd, a, d};
        rd = '0;
        for (i = ICP_FRAME_BITS - 1; i >= 0; i--) begin
            @(negedge core_clk);
            clkLine = 1'h0;
            // read frames release the line for the data phase
            dataOe = !(cmd == 1'h0 && i < WORD_W);
            dataDrive = bits[i];
            repeat (5) @(negedge core_clk);
            clkLine = 1'h1;
            if (i < WORD_W) begin
                rd[i] = pinLevel;
            end
            repeat (4) @(negedge core_clk);
        end
        @(negedge core_clk);
        clkLine = 1'h0;
        dataOe = 1'h0;
    endtask
endmodule

// file: testbench/test_program_memory_table_read.sv
// self-checking bench for program fetch, table read and programming port
`timescale 1ns/1ps
module test_program_memory_table_read;
    import pmt_pkg::*;

    // ========================================
    // design pins and bench state
    logic core_clk, arst_n, fetchAdvance, pcLoad, instrValid_r;
    logic tableReadStart, tableReadExtended, tableBusy_r, dmWrEn_r;
    logic latchWrEn, devOut, devOe, progClk, progOut, progOe;
    logic lastLevel, pinLevel;
    addr_t pcLoadAddr, pc_r, instrAddr_r;
    word_t instrWord_r, rd;
    word_t mem [addr_t];
    addr_t addrs[$];
    byte_t tablePtrLow, tablePtrHigh, destOffset, dmWrData_r;
    byte_t latchWrData, tableDataHighLatch_r;
    sector_t destSector;
    dm_addr_t dmWrAddr_r;
    logic [31:0] rngState = 32'h00000049;
    logic [31:0] rv;
    int failCount = 0;
    int checks = 0;

    program_memory_table_read DUT (
        .core_clk(core_clk), .arst_n(arst_n),
        .fetchAdvance(fetchAdvance), .pcLoad(pcLoad),
        .pcLoadAddr(pcLoadAddr), .pc_r(pc_r), .instrValid_r(instrValid_r),
        .instrAddr_r(instrAddr_r), .instrWord_r(instrWord_r),
        .tableReadStart(tableReadStart),
        .tableReadExtended(tableReadExtended),
        .tablePtrLow(tablePtrLow), .tablePtrHigh(tablePtrHigh),
        .destSector(destSector), .destOffset(destOffset),
        .tableBusy_r(tableBusy_r), .dmWrEn_r(dmWrEn_r),
        .dmWrAddr_r(dmWrAddr_r), .dmWrData_r(dmWrData_r),
        .latchWrEn(latchWrEn), .latchWrData(latchWrData),
        .tableDataHighLatch_r(tableDataHighLatch_r),
        .programPortClockLine(progClk), .programPortDataLineIn(pinLevel),
        .programPortDataLineOut_r(devOut), .programPortDataLineOe_r(devOe)
    );

    icp_programmer programmer (
        .core_clk(core_clk), .pinLevel(pinLevel), .clkLine(progClk),
        .dataDrive(progOut), .dataOe(progOe)
    );

    // ========================================
    // data pin: undriven line shows the inverse of its last level
    assign pinLevel = devOe ? devOut : (progOe ? progOut : ~lastLevel);
    always @(posedge core_clk) begin
        if (devOe | progOe) begin
            lastLevel <= pinLevel;
        end
    end

    initial begin
        core_clk = 1'h0;
        forever #12.5 core_clk = ~core_clk;
    end

    // ========================================
    // expectations and reporting
    function logic [31:0] nextRand();
        rngState ^= rngState << 13;
        rngState ^= rngState >> 17;
        rngState ^= rngState << 5;
        return rngState;
    endfunction

    function automatic addr_t tableAddr(byte_t hi, byte_t lo);
        return {hi[PTR_HI_USED-1:0], lo};
    endfunction

    function automatic dm_addr_t destAddr(logic ext, sector_t s, byte_t o);
        return {(ext ? s : SECTOR0), o};
    endfunction

    task check(input string what, input logic [31:0] seen,
               input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task printVerdict();
        $display("checks %0d mismatches %0d", checks, failCount);
        if (failCount == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ========================================
    // transfer tasks
    task programWord(input addr_t a, input word_t d);
        programmer.sendFrame(ICP_CMD_WRITE, a, d, rd);
        mem[a] = d;
        // store write lands a few cycles after the last edge
        repeat (4) @(negedge core_clk);
    endtask

    task fetchRun(input addr_t start, input int n, input logic load);
        int i;
        @(negedge core_clk);
        fetchAdvance = 1'h1;
        if (load) begin
            pcLoad = 1'h1;
            pcLoadAddr = start;
            @(negedge core_clk);
            pcLoad = 1'h0;
        end
        check("pc start", pc_r, start);
        for (i = 0; i <= n; i++) begin
            @(negedge core_clk);
            if (i == n - 1) begin
                fetchAdvance = 1'h0;
            end
            check("fetch valid", instrValid_r, i > 0);
            if (i > 0) begin
                check("fetch addr", instrAddr_r, start + i - 1);
                check("fetch word", instrWord_r, mem[start+i-1]);
            end
        end
        // the counter is 13 bits wide, so a run past 1FFFH wraps to zero
        check("pc end", pc_r, addr_t'(start + n));
        @(negedge core_clk);
        check("fetch pulse", instrValid_r, 1'h0);
    endtask

    task tableRead(input byte_t hi, input byte_t lo, input logic ext,
                   input sector_t s, input byte_t o, input logic clash);
        addr_t a;
        addr_t pc0;
        @(negedge core_clk);
        a = tableAddr(hi, lo);
        pc0 = pc_r;
        tableReadStart = 1'h1;
        tableReadExtended = ext;
        tablePtrHigh = hi;
        tablePtrLow = lo;
        destSector = s;
        destOffset = o;
        // fetch requests during the stall must be ignored
        fetchAdvance = 1'h1;
        @(negedge core_clk);
        tableReadStart = 1'h0;
        tablePtrLow = ~lo;
        destOffset = ~o;
        check("busy 1", tableBusy_r, 1'h1);
        check("early write", dmWrEn_r, 1'h0);
        @(negedge core_clk);
        check("busy 2", tableBusy_r, 1'h1);
        latchWrEn = clash;
        latchWrData = ~mem[a][15:8];
        @(negedge core_clk);
        latchWrEn = 1'h0;
        fetchAdvance = 1'h0;
        check("busy end", tableBusy_r, 1'h0);
        check("dm strobe", dmWrEn_r, 1'h1);
        check("dm addr", dmWrAddr_r, destAddr(ext, s, o));
        check("dm data", dmWrData_r, mem[a][7:0]);
        check("high latch", tableDataHighLatch_r, mem[a][15:8]);
        check("pc held", pc_r, pc0);
        @(negedge core_clk);
        check("dm pulse", dmWrEn_r, 1'h0);
    endtask

    task latchWrite(input byte_t d);
        @(negedge core_clk);
        latchWrEn = 1'h1;
        latchWrData = d;
        @(negedge core_clk);
        latchWrEn = 1'h0;
        check("latch sw", tableDataHighLatch_r, d);
    endtask

    // ========================================
    // main sequence
    initial begin
        {arst_n, fetchAdvance, pcLoad, tableReadStart, latchWrEn} = '0;
        {tableReadExtended, lastLevel} = '0;
        {pcLoadAddr, tablePtrLow, tablePtrHigh, destOffset} = '0;
        {latchWrData, destSector} = '0;
        repeat (8) @(negedge core_clk);
        check("reset pc", pc_r, RESET_VECTOR);
        check("reset valid", instrValid_r, 1'h0);
        check("reset oe", devOe, 1'h0);
        arst_n = 1'h1;
        repeat (4) @(negedge core_clk);
        addrs = '{13'h0000, 13'h0001, 13'h0002, 13'h0003, 13'h1F05,
                  13'h1F06, 13'h1FFE, 13'h1FFF};
        rv = nextRand();
        addrs.push_back(rv[12:0]);
        foreach (addrs[i]) begin
            rv = nextRand();
            programWord(addrs[i], rv[15:0]);
        end
        fetchRun(RESET_VECTOR, 4, 1'h0);
        fetchRun(13'h1FFE, 2, 1'h1);
        programmer.sendFrame(1'h0, 13'h1F06, 16'h0000, rd);
        check("icp read", rd, mem[13'h1F06]);
        check("icp release", devOe, 1'h0);
        tableRead(8'h1F, 8'h06, 1'h0, 3'h5, 8'h40, 1'h0);
        tableRead(8'hFF, 8'hFF, 1'h1, 3'h7, 8'hFF, 1'h1);
        for (int k = 0; k < 16; k++) begin
            rv = nextRand();
            pcLoadAddr = addrs[rv[27:24] % addrs.size()];
            tableRead({rv[7:5], pcLoadAddr[12:8]}, pcLoadAddr[7:0], rv[8],
                      rv[11:9], rv[19:12], rv[20]);
        end
        latchWrite(8'hA5);
        latchWrite(rv[7:0]);
        printVerdict();
    end

    // ========================================
    // watchdog: the whole run needs under 5000 cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        failCount++;
        printVerdict();
    end
endmodule
